// ### verif/ssa_alu_tb.sv
/*
 * Self-checking bench for the subtract and nibble-swap datapath.
 * Assumes the bench plays the file array and loads the accumulator and
 * flags through the load ports; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i        = 1'b0;
   logic        nrst_i        = 1'b0;
   logic        instr_valid_i = 1'b0;
   logic [13:0] instr_i       = 14'h0000;
   logic [7:0]  file_rdata_i  = 8'h00;
   logic        acc_wr_i      = 1'b0;
   logic [7:0]  acc_wdata_i   = 8'h00;
   logic        flags_wr_i    = 1'b0;
   logic [2:0]  flags_wdata_i = 3'h0;
   logic [6:0]  file_addr_o;
   logic        file_wr_o;
   logic [6:0]  file_waddr_o;
   logic [7:0]  file_wdata_o;
   logic [7:0]  acc_o;
   logic        carry_o;
   logic        nibble_carry_flag_o;
   logic        zero_o;
   int          failures = 0;
   int          n_tests  = 0;
   int          n_cyc    = 0;

   ssa_alu ssa_alu_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .file_rdata_i(file_rdata_i), .acc_wr_i(acc_wr_i),
      .acc_wdata_i(acc_wdata_i), .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i),
      .file_addr_o(file_addr_o), .file_wr_o(file_wr_o), .file_waddr_o(file_waddr_o),
      .file_wdata_o(file_wdata_o), .acc_o(acc_o), .carry_o(carry_o),
      .nibble_carry_flag_o(nibble_carry_flag_o), .zero_o(zero_o));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // A hung handshake cannot occur here, but a stuck run still ends.
   always @(posedge mclk_i) begin
      n_cyc++;
      if (n_cyc == 2000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [7:0] flg();
      return {5'h00, zero_o, nibble_carry_flag_o, carry_o};
   endfunction : flg

   task automatic load(input logic [7:0] a, input logic [2:0] f);
      @(negedge mclk_i);
      acc_wr_i = 1'b1;
      acc_wdata_i = a;
      flags_wr_i = 1'b1;
      flags_wdata_i = f;
      @(negedge mclk_i);
      acc_wr_i = 1'b0;
      flags_wr_i = 1'b0;
   endtask : load

   // Presents one instruction for one cycle; results are checked on return.
   task automatic do_op(input logic [13:0] ins, input logic [7:0] rd);
      @(negedge mclk_i);
      instr_valid_i = 1'b1;
      instr_i = ins;
      file_rdata_i = rd;
      #1 chk("file_addr", {1'b0, ins[6:0]}, {1'b0, file_addr_o});
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
   endtask : do_op

   // Literal form uses dest as the ignored bit eight.
   task automatic run_sub(input logic lit, input logic dest, input logic [7:0] a,
                          input logic [7:0] k);
      logic [6:0] adr;
      logic [7:0] d;
      adr = a[6:0] ^ 7'h2A;
      d = k - a;
      load(a, 3'h0);
      if (lit) begin
         do_op({5'h1E, dest, k}, ~k);
      end else begin
         do_op({6'h02, dest, adr}, k);
      end
      if (dest && !lit) begin
         chk("file_wr", 8'h01, {7'h00, file_wr_o});
         chk("file_waddr", {1'b0, adr}, {1'b0, file_waddr_o});
         chk("file_wdata", d, file_wdata_o);
         chk("acc kept", a, acc_o);
      end else begin
         chk("acc", d, acc_o);
         chk("file_wr idle", 8'h00, {7'h00, file_wr_o});
      end
      chk("flags", {5'h00, d == 8'h00, k[3:0] >= a[3:0], k >= a}, flg());
      @(negedge mclk_i);
      chk("file_wr pulse end", 8'h00, {7'h00, file_wr_o});
   endtask : run_sub

   task automatic run_swap(input logic dest, input logic [7:0] v);
      logic [7:0] s;
      s = {v[3:0], v[7:4]};
      load(8'h3C, 3'h5);
      do_op({6'h0E, dest, 7'h11}, v);
      chk("swap dest", s, dest ? file_wdata_o : acc_o);
      if (dest) begin
         chk("swap waddr", 8'h11, {1'b0, file_waddr_o});
      end
      chk("swap acc", dest ? 8'h3C : s, acc_o);
      chk("swap wr", {7'h00, dest}, {7'h00, file_wr_o});
      chk("swap flags", 8'h05, flg());
   endtask : run_swap

   task automatic run_other();
      load(8'h77, 3'h2);
      do_op(14'h3A0F, 8'h12);
      chk("other acc", 8'h77, acc_o);
      chk("other flags", 8'h02, flg());
      chk("other wr", 8'h00, {7'h00, file_wr_o});
   endtask : run_other

   // Back-to-back ops: the literal subtract uses the accumulator that the file
   // subtract has just written, and loads offered beside an op are lost.
   task automatic run_chain();
      load(8'h02, 3'h0);
      @(negedge mclk_i);
      instr_valid_i = 1'b1;
      instr_i = {6'h02, 1'b0, 7'h05};
      file_rdata_i = 8'h05;
      acc_wr_i = 1'b1;
      acc_wdata_i = 8'hAA;
      flags_wr_i = 1'b1;
      flags_wdata_i = 3'h6;
      @(negedge mclk_i);
      chk("chain first acc", 8'h03, acc_o);
      chk("chain first flags", 8'h03, flg());
      instr_i = {5'h1E, 1'b0, 8'h10};
      acc_wr_i = 1'b0;
      flags_wr_i = 1'b0;
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
      chk("chain acc", 8'h0D, acc_o);
      chk("chain flags", 8'h01, flg());
      chk("chain wr", 8'h00, {7'h00, file_wr_o});
   endtask : run_chain

   initial begin
      repeat (5) @(negedge mclk_i);
      chk("reset acc", 8'h00, acc_o);
      chk("reset flags", 8'h00, flg());
      chk("reset wr", 8'h00, {7'h00, file_wr_o});
      nrst_i = 1'b1;
      run_sub(1'b1, 1'b0, 8'h01, 8'h02);
      run_sub(1'b1, 1'b0, 8'h02, 8'h02);
      run_sub(1'b1, 1'b0, 8'h03, 8'h02);
      run_sub(1'b1, 1'b1, 8'h18, 8'h21);
      run_sub(1'b1, 1'b0, 8'h00, 8'hFF);
      run_sub(1'b0, 1'b0, 8'h02, 8'h03);
      run_sub(1'b0, 1'b1, 8'h02, 8'h03);
      run_sub(1'b0, 1'b1, 8'h02, 8'h02);
      run_sub(1'b0, 1'b1, 8'h02, 8'h01);
      run_sub(1'b0, 1'b0, 8'hFF, 8'h00);
      run_swap(1'b0, 8'hA5);
      run_swap(1'b1, 8'h0F);
      run_other();
      run_chain();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire

// ### verilog/ssa_alu.sv
/*
 * Execution datapath for literal subtract, file subtract and nibble swap.
 * Holds the working accumulator and the carry, nibble carry and zero flags.
 * Assumes the file array returns the addressed byte combinationally on
 * file_rdata_i for file_addr_o in the same cycle as the instruction.
 */
`timescale 1ns/1ps
`default_nettype none
module ssa_alu (
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        instr_valid_i,
   input  wire logic [13:0] instr_i,
   input  wire logic [7:0]  file_rdata_i,
   input  wire logic        acc_wr_i,
   input  wire logic [7:0]  acc_wdata_i,
   input  wire logic        flags_wr_i,
   input  wire logic [2:0]  flags_wdata_i,
   output logic      [6:0]  file_addr_o,
   output logic             file_wr_o,
   output logic      [6:0]  file_waddr_o,
   output logic      [7:0]  file_wdata_o,
   output logic      [7:0]  acc_o,
   output logic             carry_o,
   output logic             nibble_carry_flag_o,
   output logic             zero_o
);
   ssa_op_if op ();

   logic       lit_hit;
   logic       fsub_hit;
   logic       swap_hit;
   logic       sub_hit;
   logic       dest_file;
   logic [7:0] result;

   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   logic       carry_r;
   logic       carry_nxt;
   logic       nib_r;
   logic       nib_nxt;
   logic       zero_r;
   logic       zero_nxt;
   logic       fwr_r;
   logic       fwr_nxt;
   logic [6:0] fwaddr_r;
   logic [6:0] fwaddr_nxt;
   logic [7:0] fwdata_r;
   logic [7:0] fwdata_nxt;

   ssa_arith u_arith (
      .op (op.unit)
   );

   // Opcode recognition; bit 8 of the literal form is a don't-care.
   always_comb begin
      lit_hit   = instr_valid_i &&
                  (instr_i[ssa_pkg::LIT_OPC_MSB:ssa_pkg::LIT_OPC_LSB] == ssa_pkg::LIT_OPC);
      fsub_hit  = instr_valid_i &&
                  (instr_i[ssa_pkg::FILE_OPC_MSB:ssa_pkg::FILE_OPC_LSB] == ssa_pkg::FSUB_OPC);
      swap_hit  = instr_valid_i &&
                  (instr_i[ssa_pkg::FILE_OPC_MSB:ssa_pkg::FILE_OPC_LSB] == ssa_pkg::SWAP_OPC);
      sub_hit   = lit_hit || fsub_hit;
      dest_file = instr_i[ssa_pkg::DEST_BIT];
   end

   // Operand selection: literal or addressed file byte, minus accumulator.
   always_comb begin
      file_addr_o   = instr_i[ssa_pkg::FADDR_MSB:0];
      op.minuend    = lit_hit ? instr_i[ssa_pkg::LIT_MSB:0] : file_rdata_i;
      op.subtrahend = acc_r;
      result        = swap_hit ? op.swapped : op.diff;
   end

   // Next-state logic for accumulator, flags and file write port.
   always_comb begin
      acc_nxt    = acc_r;
      carry_nxt  = carry_r;
      nib_nxt    = nib_r;
      zero_nxt   = zero_r;
      fwr_nxt    = 1'b0;
      fwaddr_nxt = fwaddr_r;
      fwdata_nxt = fwdata_r;
      // Loads from outside lose to any op that is taken in the same cycle.
      if (lit_hit) begin
         acc_nxt = op.diff;
      end else if (fsub_hit || swap_hit) begin
         if (dest_file == ssa_pkg::DEST_FILE) begin
            fwr_nxt    = 1'b1;
            fwaddr_nxt = file_addr_o;
            fwdata_nxt = result;
         end else begin
            acc_nxt = result;
         end
      end else if (acc_wr_i) begin
         acc_nxt = acc_wdata_i;
      end
      if (sub_hit) begin
         carry_nxt = op.carry;
         nib_nxt   = op.nib_carry;
         zero_nxt  = op.zero;
      end else if (flags_wr_i && !swap_hit) begin
         carry_nxt = flags_wdata_i[ssa_pkg::FLAG_C];
         nib_nxt   = flags_wdata_i[ssa_pkg::FLAG_DC];
         zero_nxt  = flags_wdata_i[ssa_pkg::FLAG_Z];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         acc_r    <= ssa_pkg::ACC_RST;
         carry_r  <= ssa_pkg::FLAGS_RST[ssa_pkg::FLAG_C];
         nib_r    <= ssa_pkg::FLAGS_RST[ssa_pkg::FLAG_DC];
         zero_r   <= ssa_pkg::FLAGS_RST[ssa_pkg::FLAG_Z];
         fwr_r    <= 1'b0;
         fwaddr_r <= ssa_pkg::FWADDR_RST;
         fwdata_r <= ssa_pkg::FWDATA_RST;
      end else begin
         acc_r    <= acc_nxt;
         carry_r  <= carry_nxt;
         nib_r    <= nib_nxt;
         zero_r   <= zero_nxt;
         fwr_r    <= fwr_nxt;
         fwaddr_r <= fwaddr_nxt;
         fwdata_r <= fwdata_nxt;
      end
   end

   always_comb begin
      acc_o               = acc_r;
      carry_o             = carry_r;
      nibble_carry_flag_o = nib_r;
      zero_o              = zero_r;
      file_wr_o           = fwr_r;
      file_waddr_o        = fwaddr_r;
      file_wdata_o        = fwdata_r;
   end

   // Checks on the datapath, sampled against the cycle that carried the op.
   a_lit_result: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      lit_hit |=> acc_o == 8'($past(instr_i[7:0]) - $past(acc_o)) && !file_wr_o)
      else $error("literal subtract result wrong");

   a_lit_dontcare: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      instr_valid_i && instr_i[13:9] == 5'h1E |-> lit_hit && !fsub_hit && !swap_hit)
      else $error("literal subtract not decoded");

   a_fsub_acc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      fsub_hit && !instr_i[7] |=> acc_o == 8'($past(file_rdata_i) - $past(acc_o)))
      else $error("file subtract to accumulator wrong");

   a_fsub_file: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      fsub_hit && instr_i[7] |=> file_wr_o && $stable(acc_o)
         && file_waddr_o == $past(instr_i[6:0])
         && file_wdata_o == 8'($past(file_rdata_i) - $past(acc_o)))
      else $error("file subtract to file wrong");

   a_carry_borrow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      sub_hit |=> carry_o == ($past(op.minuend) >= $past(acc_o)))
      else $error("carry does not reflect borrow");

   a_swap_data: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit && instr_i[7] |=> file_wr_o
         && file_wdata_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
      else $error("swap to file wrong");

   a_swap_acc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit && !instr_i[7] |=> !file_wr_o
         && acc_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
      else $error("swap to accumulator wrong");

   a_swap_flags: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit |=> $stable(carry_o) && $stable(nibble_carry_flag_o) && $stable(zero_o))
      else $error("swap changed a flag");

   a_sub_zero_dc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      sub_hit |=> zero_o == (8'($past(op.minuend) - $past(acc_o)) == 8'h00)
         && nibble_carry_flag_o == ($past(op.minuend[3:0]) >= $past(acc_o[3:0])))
      else $error("zero or nibble carry wrong");

   a_idle_no_write: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !(fsub_hit || swap_hit) |=> !file_wr_o)
      else $error("spurious file write");

   a_fsub_acc_nowr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      fsub_hit && !instr_i[7] |=> !file_wr_o)
      else $error("file subtract to accumulator wrote the file");

   a_swap_keeps_acc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit && instr_i[7] |=> $stable(acc_o))
      else $error("swap to file changed the accumulator");

   a_wr_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      file_wr_o |=> !file_wr_o || $past((fsub_hit || swap_hit) && dest_file))
      else $error("file write pulse too long");

   a_other_quiet: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      instr_valid_i && !lit_hit && !fsub_hit && !swap_hit && !acc_wr_i && !flags_wr_i
      |=> $stable(acc_o) && $stable(carry_o) && $stable(nibble_carry_flag_o)
         && $stable(zero_o) && !file_wr_o)
      else $error("unknown opcode changed state");

   // Covers for the main scenarios.
   c_swap_file: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit && instr_i[7]);
   c_lit_negative: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      lit_hit && !op.carry);
   c_fsub_zero: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      fsub_hit && instr_i[7] && op.zero);
   c_swap_acc: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      swap_hit && !instr_i[7]);
   c_back_to_back: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      fsub_hit ##1 lit_hit);
endmodule : ssa_alu
`default_nettype wire

// ### verilog/ssa_arith.sv
/*
 * Arithmetic unit: two's complement subtract with carry, nibble carry and
 * zero, plus the nibble exchange of the minuend.
 * Assumes operands are held stable by the user for the cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ssa_arith (
   ssa_op_if.unit op
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   always_comb begin
      // Subtraction as a + ~b + 1; a carry out means no borrow.
      full_sum     = {1'b0, op.minuend} + {1'b0, ~op.subtrahend} + 9'h001;
      low_sum      = {1'b0, op.minuend[3:0]} + {1'b0, ~op.subtrahend[3:0]} + 5'h01;
      op.diff      = full_sum[7:0];
      op.carry     = full_sum[8];
      op.nib_carry = low_sum[4];
      op.zero      = (full_sum[7:0] == 8'h00);
      op.swapped   = {op.minuend[3:0], op.minuend[7:4]};
   end
endmodule : ssa_arith
`default_nettype wire

// ### verilog/ssa_op_if.sv
/*
 * Carrier between the datapath top and its arithmetic unit.
 * Assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface ssa_op_if;
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic [7:0] diff;
   logic [7:0] swapped;
   logic       carry;
   logic       nib_carry;
   logic       zero;

   modport unit (input minuend, subtrahend, output diff, swapped, carry, nib_carry, zero);
   modport user (output minuend, subtrahend, input diff, swapped, carry, nib_carry, zero);
endinterface : ssa_op_if
`default_nettype wire

// ### verilog/ssa_pkg.sv
/*
 * Shared constants for the subtract and nibble-swap datapath: opcode
 * patterns, field positions, widths and reset values.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
`default_nettype none
package ssa_pkg;
   localparam int          INSTR_W       = 14;
   localparam int          DATA_W        = 8;
   localparam int          FADDR_W       = 7;
   localparam int          NIB_W         = 4;
   // Literal subtract: 11 110x kkkk kkkk, bit 8 is ignored.
   localparam int          LIT_OPC_MSB   = 13;
   localparam int          LIT_OPC_LSB   = 9;
   localparam logic [4:0]  LIT_OPC       = 5'h1E;
   // File subtract 00 0010 dfff ffff and swap 00 1110 dfff ffff.
   localparam int          FILE_OPC_MSB  = 13;
   localparam int          FILE_OPC_LSB  = 8;
   localparam logic [5:0]  FSUB_OPC      = 6'h02;
   localparam logic [5:0]  SWAP_OPC      = 6'h0E;
   localparam int          DEST_BIT      = 7;
   localparam int          LIT_MSB       = 7;
   localparam int          FADDR_MSB     = 6;
   localparam logic        DEST_ACC      = 1'b0;
   localparam logic        DEST_FILE     = 1'b1;
   // Flag vector layout on the flag load port.
   localparam int          FLAG_C        = 0;
   localparam int          FLAG_DC       = 1;
   localparam int          FLAG_Z        = 2;
   localparam logic [7:0]  ACC_RST       = 8'h00;
   localparam logic [2:0]  FLAGS_RST     = 3'h0;
   localparam logic [6:0]  FWADDR_RST    = 7'h00;
   localparam logic [7:0]  FWDATA_RST    = 8'h00;
   localparam int          OP_CYCLES     = 1;
endpackage : ssa_pkg
`default_nettype wire
